// ---- dv/cprc_common_pins_sva.sv ----
`timescale 1ns/1ns
module cprc_common_pins_sva (
    // Watched ports
    input wire logic SYS_CLK_I,
    input wire logic RESET_N_I,
    input wire logic CLK_EN_I,
    input wire logic SUPPLY_OK_I,
    input wire logic EXT_RESET_N_I,
    input wire logic USB_CONFIGURED_I,
    input wire logic USB_SUSPEND_I,
    input wire logic EEPROM_SELECT_OE_O,
    input wire logic EEPROM_CLK_OE_O,
    input wire logic EEPROM_DATA_OE_O,
    input wire logic PULLUP_EN_O,
    input wire logic RESET_GEN_OUT_N_O,
    input wire logic DEVICE_RESET_O,
    input wire logic POWER_SWITCH_EN_N_O,
    input wire logic OSC_DRIVE_OUT_O
);
    logic [19:0] good_cnt_reg;
    default clocking @(posedge SYS_CLK_I); endclocking
    default disable iff (!RESET_N_I);
    // Enabled edges since supply and external reset were last both good
    always_ff @(posedge SYS_CLK_I) begin
        if (!RESET_N_I || !SUPPLY_OK_I || !EXT_RESET_N_I) begin
            good_cnt_reg <= 20'h0;
        end else if (CLK_EN_I && good_cnt_reg != 20'hfffff) begin
            good_cnt_reg <= good_cnt_reg + 20'h1;
        end
    end
    AST_RST_LEN: assert property ($rose(RESET_GEN_OUT_N_O) |->
        good_cnt_reg inside {[20'h833e:20'h8342]}) else $error("reset low period wrong");
    AST_EXT_RST: assert property (CLK_EN_I && !EXT_RESET_N_I |=> !RESET_GEN_OUT_N_O)
        else $error("external reset ignored");
    AST_SUPPLY: assert property (CLK_EN_I && !SUPPLY_OK_I |=> !RESET_GEN_OUT_N_O)
        else $error("reset released with bad supply");
    AST_SEL_DAT_Z: assert property (DEVICE_RESET_O |->
        !EEPROM_SELECT_OE_O && !EEPROM_DATA_OE_O) else $error("pad driven in reset");
    AST_CLK_OE: assert property (EEPROM_CLK_OE_O == !DEVICE_RESET_O)
        else $error("clock pad drive wrong");
    AST_PULLUP: assert property (PULLUP_EN_O == DEVICE_RESET_O &&
        DEVICE_RESET_O == !RESET_GEN_OUT_N_O) else $error("pull-up state wrong");
    AST_PWR_OFF: assert property (CLK_EN_I && USB_SUSPEND_I |=> POWER_SWITCH_EN_N_O)
        else $error("power on in suspend");
    AST_PWR_ON: assert property (CLK_EN_I && USB_CONFIGURED_I && !USB_SUSPEND_I &&
        EXT_RESET_N_I && !DEVICE_RESET_O |=> !POWER_SWITCH_EN_N_O) else $error("power not on");
    AST_OSC_STOP: assert property (CLK_EN_I && USB_SUSPEND_I |=> !OSC_DRIVE_OUT_O)
        else $error("oscillator runs in suspend");
    cover property ($rose(RESET_GEN_OUT_N_O));
    cover property ($fell(POWER_SWITCH_EN_N_O));
    cover property (USB_SUSPEND_I && !DEVICE_RESET_O);
endmodule : cprc_common_pins_sva
bind cprc_common_pins cprc_common_pins_sva u_sva (.*);

// ---- dv/cprc_common_pins_tb.sv ----
`timescale 1ns/1ns
module cprc_common_pins_tb;
    logic SYS_CLK_I = 1'b0, RESET_N_I = 1'b0, CLK_EN_I = 1'b1, SUPPLY_OK_I = 1'b1;
    logic EXT_RESET_N_I = 1'b1, TEST_MODE_I = 1'b0, USB_BUS_RESET_I = 1'b0;
    logic USB_CONFIGURED_I = 1'b1, USB_SUSPEND_I = 1'b0, EE_SEL_I = 1'b0, EE_CLK_I = 1'b0;
    logic EE_DATA_I = 1'b0, EE_DATA_DRIVE_I = 1'b0, EEPROM_DATA_I, EEPROM_SELECT_O;
    logic EEPROM_SELECT_OE_O, EEPROM_CLK_O, EEPROM_CLK_OE_O, EEPROM_DATA_O, EEPROM_DATA_OE_O;
    logic PULLUP_EN_O, EE_DATA_IN_O, RESET_GEN_OUT_N_O, DEVICE_RESET_O, POWER_SWITCH_EN_N_O;
    logic OSC_DRIVE_OUT_O, mon_on = 1'b0, osc_seen;
    logic [1:0] prev = 2'b01;
    logic [1:0] exp_q[$];
    logic [31:0] seed = 32'h00000ef0;
    int fail_count = 0, checked = 0, cycles = 0;
    cprc_common_pins u_dut (.*);
    cprc_ee_model u_ee (.sel_i(EEPROM_SELECT_O & EEPROM_SELECT_OE_O), .sclk_i(EEPROM_CLK_O),
        .pad_i(EEPROM_DATA_O), .pad_oe_i(EEPROM_DATA_OE_O), .pullup_i(PULLUP_EN_O),
        .pad_o(EEPROM_DATA_I));
    function automatic logic [31:0] xs(input logic [31:0] x);
        x = x ^ (x << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction : xs
    task automatic chk(input logic [31:0] seen, input logic [31:0] want);
        checked++;
        if (seen !== want) begin
            fail_count++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, want);
        end
    endtask : chk
    task automatic give_verdict();
        $display("checked %0d fail_count %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : give_verdict
    //////////////////////////////////////////////////////////////////////////////
    always #5 SYS_CLK_I = ~SYS_CLK_I;
    // 6 MHz source is abstracted to the system clock; bus reset toggles at random
    always @(posedge SYS_CLK_I) begin
        #1;
        seed = xs(seed);
        {EE_SEL_I, EE_CLK_I, EE_DATA_I, EE_DATA_DRIVE_I, USB_BUS_RESET_I} <= seed[4:0];
        cycles++;
        if (cycles == 40000) begin
            fail_count++;
            give_verdict();
        end
    end
    // Any change of reset or power output must match the oldest note
    always @(posedge SYS_CLK_I) begin
        #2;
        if (mon_on && {RESET_GEN_OUT_N_O, POWER_SWITCH_EN_N_O} !== prev) begin
            chk({RESET_GEN_OUT_N_O, POWER_SWITCH_EN_N_O},
                exp_q.size() ? exp_q.pop_front() : prev);
        end
        prev = {RESET_GEN_OUT_N_O, POWER_SWITCH_EN_N_O};
    end
    //////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (5) @(posedge SYS_CLK_I);
        #1 RESET_N_I = 1'b1;
        mon_on = 1'b1;
        exp_q = '{2'b11, 2'b10};
        while (RESET_GEN_OUT_N_O !== 1'b1) @(posedge SYS_CLK_I);
        repeat (3) @(posedge SYS_CLK_I);
        #3 chk({EEPROM_SELECT_OE_O, EEPROM_CLK_OE_O, PULLUP_EN_O, EEPROM_DATA_OE_O},
            {3'b110, EE_DATA_DRIVE_I});
        // First suspend, then loss of configuration
        for (int i = 0; i < 2; i++) begin
            @(posedge SYS_CLK_I);
            #1 USB_SUSPEND_I = (i == 0);
            USB_CONFIGURED_I = (i == 0);
            exp_q.push_back(2'b11);
            repeat (3) @(posedge SYS_CLK_I);
            #3 osc_seen = OSC_DRIVE_OUT_O;
            @(posedge SYS_CLK_I);
            #3 chk({osc_seen, OSC_DRIVE_OUT_O}, (i == 0) ? 2'b00 : {osc_seen, ~osc_seen});
            @(posedge SYS_CLK_I);
            #1 USB_SUSPEND_I = 1'b0;
            USB_CONFIGURED_I = 1'b1;
            exp_q.push_back(2'b10);
            repeat (3) @(posedge SYS_CLK_I);
        end
        @(posedge SYS_CLK_I);
        #1 mon_on = 1'b0;
        EXT_RESET_N_I = 1'b0;
        repeat (2) @(posedge SYS_CLK_I);
        #3 chk({RESET_GEN_OUT_N_O, DEVICE_RESET_O, PULLUP_EN_O, EEPROM_SELECT_OE_O,
            EEPROM_CLK_OE_O, EEPROM_DATA_OE_O, POWER_SWITCH_EN_N_O, EE_DATA_IN_O},
            8'h63);
        chk(exp_q.size(), 0);
        give_verdict();
    end
endmodule : cprc_common_pins_tb

// ---- dv/cprc_ee_model.sv ----
`timescale 1ns/1ns
module cprc_ee_model (
    // Pads
    input wire logic sel_i,
    input wire logic sclk_i,
    input wire logic pad_i,
    input wire logic pad_oe_i,
    input wire logic pullup_i,
    output logic pad_o
);
    logic bit_reg = 1'b0;
    always @(posedge sclk_i) if (sel_i) bit_reg <= pad_i;
    // Device drive wins over the series resistor; released line sits at the pull-ups in reset or when deselected, else the EEPROM drives it
    assign pad_o = pad_oe_i ? pad_i : (pullup_i || !sel_i) ? 1'b1 : ~bit_reg;
endmodule : cprc_ee_model

// ---- hdl/cprc_common_pins.sv ----
`timescale 1ns/1ns
`include "cprc_regs.svh"

// How it works
// [R1] Reset output stays low 5.6 ms after supply and clock are good, then rises.
// [R2] External reset input low forces the reset output low.
// [R3] A USB bus reset never touches the reset output.
// [R4] External party may reset device through its reset input; tie high if unused.
// [R5] EEPROM chip select floats during reset.
// [R6] EEPROM clock floats during reset, driven otherwise.
// [R7] One shared EEPROM data pin, floating in reset; board adds series resistor.
// [R8] Floating EEPROM pins and reset input get weak pull-ups during reset.
// [R9] Power enable goes low once configured, high during suspend.
// [R10] Board enables interface pull-down option when power enable switches logic.
// [R11] Oscillator output stops toggling during suspend.
// [R12] Test input must be held low for normal operation.
// [R13] Device clock comes from a 6 MHz crystal or equivalent source.
// [R14] Low period counted on internal clock; release synchronous to that clock.
module cprc_common_pins (
    // Clock and reset
    input wire logic SYS_CLK_I,
    input wire logic RESET_N_I,
    input wire logic CLK_EN_I,
    // Supply and external reset
    input wire logic SUPPLY_OK_I,
    input wire logic EXT_RESET_N_I,
    input wire logic TEST_MODE_I,
    // USB state
    input wire logic USB_BUS_RESET_I,
    input wire logic USB_CONFIGURED_I,
    input wire logic USB_SUSPEND_I,
    // EEPROM engine side
    input wire logic EE_SEL_I,
    input wire logic EE_CLK_I,
    input wire logic EE_DATA_I,
    input wire logic EE_DATA_DRIVE_I,
    // EEPROM pads
    output logic EEPROM_SELECT_O,
    output logic EEPROM_SELECT_OE_O,
    output logic EEPROM_CLK_O,
    output logic EEPROM_CLK_OE_O,
    output logic EEPROM_DATA_O,
    output logic EEPROM_DATA_OE_O,
    input wire logic EEPROM_DATA_I,
    output logic PULLUP_EN_O,
    // Outputs
    output logic EE_DATA_IN_O,
    output logic RESET_GEN_OUT_N_O,
    output logic DEVICE_RESET_O,
    output logic POWER_SWITCH_EN_N_O,
    output logic OSC_DRIVE_OUT_O
);

    ////////////////////////////////////////////////////////////////////////////
    cprc_pkg::cprc_state_type state_reg;
    cprc_pkg::cprc_state_type state_next;
    logic [`CPRC_CNT_W-1:0] count_reg;
    logic [`CPRC_OSC_W-1:0] osc_cnt_reg;
    logic rst_out_n_reg;
    logic pwr_n_reg;
    logic osc_reg;
    logic ee_in_reg;
    logic timer_done;
    logic in_reset;

    cprc_pin_if pin_bus ();

    // The USB bus reset input is deliberately left out of every term below
    assign timer_done = (count_reg == `CPRC_CNT_W'(`CPRC_RST_LOW_CYCLES - 1)); // [R3]
    assign in_reset = !rst_out_n_reg;

    ////////////////////////////////////////////////////////////////////////////
    // Reset generator timer, restarted by bad supply or external reset
    always_ff @(posedge SYS_CLK_I) begin
        if (!RESET_N_I) begin
            count_reg <= '0;
        end else if (CLK_EN_I) begin
            if (!SUPPLY_OK_I || !EXT_RESET_N_I) begin // [R4]
                count_reg <= '0;
            end else if (!timer_done) begin
                count_reg <= count_reg + `CPRC_CNT_W'(1); // [R14]
            end
        end
    end

    always_ff @(posedge SYS_CLK_I) begin
        if (!RESET_N_I) begin
            rst_out_n_reg <= 1'b0;
        end else if (CLK_EN_I) begin
            if (!SUPPLY_OK_I || !EXT_RESET_N_I) begin
                rst_out_n_reg <= 1'b0; // [R2]
            end else if (timer_done) begin
                rst_out_n_reg <= 1'b1; // [R1] [R14]
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Power state
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            cprc_pkg::ST_HOLD: begin
                if (USB_CONFIGURED_I && !in_reset) begin
                    state_next = USB_SUSPEND_I ? cprc_pkg::ST_SUSP : cprc_pkg::ST_RUN;
                end
            end
            cprc_pkg::ST_RUN: begin
                if (!USB_CONFIGURED_I) begin
                    state_next = cprc_pkg::ST_HOLD;
                end else if (USB_SUSPEND_I) begin
                    state_next = cprc_pkg::ST_SUSP;
                end
            end
            cprc_pkg::ST_SUSP: begin
                if (!USB_SUSPEND_I) begin
                    state_next = USB_CONFIGURED_I ? cprc_pkg::ST_RUN : cprc_pkg::ST_HOLD;
                end
            end
            default: begin
                state_next = cprc_pkg::ST_HOLD;
            end
        endcase
    end

    always_ff @(posedge SYS_CLK_I) begin
        if (!RESET_N_I) begin
            state_reg <= cprc_pkg::ST_HOLD;
        end else if (CLK_EN_I) begin
            state_reg <= in_reset ? cprc_pkg::ST_HOLD : state_next;
        end
    end

    always_ff @(posedge SYS_CLK_I) begin
        if (!RESET_N_I) begin
            pwr_n_reg <= 1'b1;
        end else if (CLK_EN_I) begin
            pwr_n_reg <= !(state_next == cprc_pkg::ST_RUN) || in_reset; // [R9]
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Oscillator output, held low while suspended
    always_ff @(posedge SYS_CLK_I) begin
        if (!RESET_N_I) begin
            osc_cnt_reg <= '0;
            osc_reg <= 1'b0;
        end else if (CLK_EN_I) begin
            if (USB_SUSPEND_I) begin
                osc_cnt_reg <= '0;
                osc_reg <= 1'b0; // [R11]
            end else if (osc_cnt_reg == `CPRC_OSC_HALF - 9'd1) begin
                osc_cnt_reg <= '0;
                osc_reg <= !osc_reg;
            end else begin
                osc_cnt_reg <= osc_cnt_reg + 9'd1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // EEPROM pads
    always_ff @(posedge SYS_CLK_I) begin
        if (!RESET_N_I) begin
            ee_in_reg <= 1'b1;
        end else if (CLK_EN_I) begin
            ee_in_reg <= EEPROM_DATA_I; // [R7]
        end
    end

    assign pin_bus.in_reset = in_reset;
    assign pin_bus.sel_val = EE_SEL_I;
    assign pin_bus.clk_val = EE_CLK_I;
    assign pin_bus.dat_val = EE_DATA_I;
    assign pin_bus.dat_drive = EE_DATA_DRIVE_I;

    cprc_eeprom_pins u_pins (
        .clk_i(SYS_CLK_I),
        .reset_n_i(RESET_N_I),
        .ce_i(CLK_EN_I),
        .pin(pin_bus.pins),
        .sel_o(EEPROM_SELECT_O),
        .sel_oe_o(EEPROM_SELECT_OE_O),
        .sclk_o(EEPROM_CLK_O),
        .sclk_oe_o(EEPROM_CLK_OE_O),
        .data_o(EEPROM_DATA_O),
        .data_oe_o(EEPROM_DATA_OE_O),
        .pullup_en_o(PULLUP_EN_O)
    );

    assign EE_DATA_IN_O = ee_in_reg;
    assign RESET_GEN_OUT_N_O = rst_out_n_reg;
    assign DEVICE_RESET_O = in_reset;
    assign POWER_SWITCH_EN_N_O = pwr_n_reg;
    assign OSC_DRIVE_OUT_O = osc_reg;

endmodule : cprc_common_pins

// ---- hdl/cprc_eeprom_pins.sv ----
`timescale 1ns/1ns

module cprc_eeprom_pins (
    // Clock
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic ce_i,
    // Control
    cprc_pin_if.pins pin,
    // Pads
    output logic sel_o,
    output logic sel_oe_o,
    output logic sclk_o,
    output logic sclk_oe_o,
    output logic data_o,
    output logic data_oe_o,
    output logic pullup_en_o
);

    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            sel_o <= 1'b0;
            sclk_o <= 1'b0;
            data_o <= 1'b0;
        end else if (ce_i) begin
            sel_o <= pin.sel_val;
            sclk_o <= pin.clk_val;
            data_o <= pin.dat_val;
        end
    end

    // Pads float during reset, with weak pull-ups in their place
    always_comb begin
        sel_oe_o = !pin.in_reset; // [R5]
        sclk_oe_o = !pin.in_reset; // [R6]
        data_oe_o = !pin.in_reset && pin.dat_drive; // [R7]
        pullup_en_o = pin.in_reset; // [R8]
    end

endmodule : cprc_eeprom_pins

// ---- hdl/cprc_pin_if.sv ----
`timescale 1ns/1ns

interface cprc_pin_if;
    logic in_reset;
    logic sel_val;
    logic clk_val;
    logic dat_val;
    logic dat_drive;

    modport ctrl (output in_reset, output sel_val, output clk_val, output dat_val,
        output dat_drive);
    modport pins (input in_reset, input sel_val, input clk_val, input dat_val,
        input dat_drive);
endinterface : cprc_pin_if

// ---- hdl/cprc_pkg.sv ----
package cprc_pkg;

    typedef enum logic [2:0] {
        ST_HOLD = 3'b001,
        ST_RUN = 3'b010,
        ST_SUSP = 3'b100
    } cprc_state_type;

endpackage : cprc_pkg

// ---- hdl/cprc_regs.svh ----
`ifndef CPRC_REGS_SVH
`define CPRC_REGS_SVH

// Reset generator low period, in microseconds, and its length in oscillator periods
// Each clock edge stands for one 6 MHz oscillator period of the device
`define CPRC_RST_LOW_US 5600
`define CPRC_CLK_MHZ 6
`define CPRC_RST_LOW_CYCLES (`CPRC_RST_LOW_US * `CPRC_CLK_MHZ)
`define CPRC_CNT_W 20
// Oscillator output divider: toggles every this many cycles
`define CPRC_OSC_HALF 9'd1
`define CPRC_OSC_W 9

`endif
